// >>> hpm_top.sv
// host port: address map, interrupts, reset sequencing, ready and arbitration
`timescale 1ns/1ns
module hpm_top (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire hpm_pkg::hpm_host_t i_host,   // raw host pins
    input wire logic i_cha_mem_req,          // channel A buffer request
    input wire logic i_chb_mem_req,          // channel B buffer request
    input wire logic i_cha_irq_event,        // channel A interrupt condition pulse
    input wire logic i_chb_irq_event,        // channel B interrupt condition pulse
    input wire logic i_refresh_tick,         // refresh period pulse
    input wire logic [7:0] i_mem_rdata,      // buffer read data
    input wire logic i_chan_done,            // channel cycle finished
    input wire logic [7:0] i_chan_rdata,     // channel read data
    output logic [7:0] o_ad,                 // host read data
    output logic o_ad_oe,                    // drive host data bus
    output logic o_rdy_n,                    // ready, low holds host
    output logic o_irq,                      // shared interrupt
    output logic o_cha_cyc,                  // channel A host cycle
    output logic o_chb_cyc,                  // channel B host cycle
    output logic [5:0] o_chan_addr,          // offset within channel window
    output logic o_chan_we,                  // channel cycle direction
    output logic [7:0] o_chan_wdata,         // channel write data
    output logic o_cha_ctl_oe,               // channel A control lines driven
    output logic o_chb_ctl_oe,               // channel B control lines driven
    output hpm_pkg::hpm_gnt_t o_mem_gnt,     // buffer grant
    output logic [19:0] o_mem_addr,          // buffer address
    output logic o_mem_we,                   // buffer write
    output logic [7:0] o_mem_wdata,          // buffer write data
    output logic o_mem_active,               // memory signals enabled
    output logic o_sram_mode,                // static RAM mode
    output logic o_refresh_force             // refresh queue full, burst ends
);
    // two-flop synchroniser on host pins
    hpm_pkg::hpm_host_t s1_q, s2_q, s3_q;
    always_ff @(posedge i_clock) begin
        s1_q <= i_host;
        s2_q <= s1_q;
        s3_q <= s2_q;  // previous value, for edge detection
    end

    // soft reset raised by a host write; combined reset
    logic soft_reset_bit_q;
    logic rst;
    assign rst = !i_nrst || soft_reset_bit_q;

    // latched address, every ALE regardless of chip select
    logic [7:0] addr_q;
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            addr_q <= 8'h00;
        end else if (s2_q.ale) begin
            addr_q <= {s2_q.ad[7:1], 1'b0};
        end
    end

    // decode: bit 7 picks the channel; low seven bits the region
    logic [6:0] off;
    logic sel_chan, sel_creg, sel_data, sel_reg, sel_zero;
    assign off = addr_q[6:0];
    assign sel_chan = off < hpm_pkg::OFF_CHAN_REGS;
    assign sel_creg = !sel_chan && off < hpm_pkg::OFF_OPT;
    assign sel_data = off == hpm_pkg::OFF_DATA_PORT;
    assign sel_reg = off >= hpm_pkg::OFF_OPT && !sel_data;
    assign sel_zero = off >= hpm_pkg::OFF_ZERO_LO && off <= hpm_pkg::OFF_ZERO_HI;

    // strobe starts qualified by chip select; strobe end is not
    logic rd_fall, wr_fall, strobe_on, strobe_end;
    assign rd_fall = !s2_q.cs_n && !s2_q.rd_n && s3_q.rd_n;
    assign wr_fall = !s2_q.cs_n && !s2_q.wr_n && s3_q.wr_n;
    assign strobe_on = rd_fall || wr_fall;
    assign strobe_end = (!s2_q.rd_n || !s2_q.wr_n) && s3_q.rd_n && s3_q.wr_n ? 1'b0 :
        ((s2_q.rd_n && !s3_q.rd_n) || (s2_q.wr_n && !s3_q.wr_n));

    // registers
    logic [7:0] opt_q, opt2_q, tsel_q, aaux_q, bdl_q;
    logic [19:0] ptr_q;
    logic [7:0] cha_ccr_q, chb_ccr_q;
    logic airq_q, birq_q;
    logic reg_wr;
    logic [7:0] wdata;
    assign reg_wr = wr_fall && sel_reg;
    assign wdata = s2_q.ad;

    // soft reset bit, self clearing after one cycle
    always_ff @(posedge i_clock) begin
        if (!i_nrst || soft_reset_bit_q) begin
            soft_reset_bit_q <= 1'b0;
        end else if (reg_wr && off == hpm_pkg::OFF_RTR) begin
            soft_reset_bit_q <= wdata[hpm_pkg::BIT_SOFT_RESET_BIT];
        end
    end

    // plain read/write registers
    always_ff @(posedge i_clock) begin
        if (rst) begin
            opt_q <= hpm_pkg::RST_OPT;
            opt2_q <= hpm_pkg::RST_ZERO;
            tsel_q <= hpm_pkg::RST_ZERO;
            aaux_q <= hpm_pkg::RST_ZERO;
        end else if (reg_wr) begin
            unique case (off)
                hpm_pkg::OFF_OPT: opt_q <= wdata;
                hpm_pkg::OFF_OPT2: opt2_q <= wdata;
                hpm_pkg::OFF_TSEL: tsel_q <= wdata;
                hpm_pkg::OFF_AAUX: aaux_q <= wdata;
                default: ;  // zero slots and others keep nothing
            endcase
        end
    end

    // memory enable after reset, set by an option write
    logic mem_on_q;
    always_ff @(posedge i_clock) begin
        if (rst) begin
            mem_on_q <= 1'b0;
        end else if (reg_wr && off == hpm_pkg::OFF_OPT) begin
            mem_on_q <= 1'b1;
        end
    end

    // channel control registers: tristate until written
    logic cha_on_q, chb_on_q;
    always_ff @(posedge i_clock) begin
        if (rst) begin
            cha_ccr_q <= hpm_pkg::RST_ZERO;
            chb_ccr_q <= hpm_pkg::RST_ZERO;
            cha_on_q <= 1'b0;
            chb_on_q <= 1'b0;
        end else if (wr_fall && sel_creg && off == hpm_pkg::OFF_CCR) begin
            if (addr_q[7]) begin
                chb_ccr_q <= wdata;
                chb_on_q <= 1'b1;
            end else begin
                cha_ccr_q <= wdata;
                cha_on_q <= 1'b1;
            end
        end
    end

    // interrupt conditions: set wins over write-one clear
    logic clr_irq;
    assign clr_irq = reg_wr && off == hpm_pkg::OFF_MSTAT;
    always_ff @(posedge i_clock) begin
        if (rst) begin
            airq_q <= 1'b0;
            birq_q <= 1'b0;
        end else begin
            airq_q <= i_cha_irq_event ||
                (airq_q && !(clr_irq && wdata[hpm_pkg::BIT_AIRQ]));
            birq_q <= i_chb_irq_event ||
                (birq_q && !(clr_irq && wdata[hpm_pkg::BIT_BIRQ]));
        end
    end

    // shared interrupt line, no priority
    always_ff @(posedge i_clock) begin
        if (rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= opt2_q[hpm_pkg::BIT_GIE] &&
                ((airq_q && opt2_q[hpm_pkg::BIT_AIE]) ||
                 (birq_q && opt2_q[hpm_pkg::BIT_BIE]));
        end
    end

    // host access engine: sync delay then arbitration or channel cycle
    typedef enum logic [2:0] {ST_IDLE, ST_SYNC, ST_MEM, ST_CHAN} hpm_st_t;
    hpm_st_t st_q;
    logic [1:0] cnt_q;
    logic acc_we_q, acc_b_q, acc_mem_q;
    logic [5:0] acc_off_q;
    logic busy;
    assign busy = st_q != ST_IDLE;

    // refresh queue, up to four pending
    logic [2:0] refq_q;
    logic ref_force;
    assign ref_force = refq_q == hpm_pkg::REF_QMAX;
    always_ff @(posedge i_clock) begin
        if (rst || !mem_on_q || opt_q[3:0] == hpm_pkg::RRC_OFF) begin
            refq_q <= 3'h0;
        end else if (ref_force) begin
            refq_q <= 3'h0;  // arbitration serves queued refreshes
        end else if (i_refresh_tick) begin
            refq_q <= refq_q + 3'h1;
        end
    end

    // sequencer; memory grant to host first
    logic mem_req_host;
    assign mem_req_host = st_q == ST_MEM;
    always_ff @(posedge i_clock) begin
        if (rst) begin
            st_q <= ST_IDLE;
            cnt_q <= 2'h0;
            acc_we_q <= 1'b0;
            acc_b_q <= 1'b0;
            acc_mem_q <= 1'b0;
            acc_off_q <= 6'h00;
            bdl_q <= hpm_pkg::RST_ZERO;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (strobe_on && (sel_data || (sel_chan &&
                        (addr_q[7] ? chb_ccr_q[hpm_pkg::BIT_MASTER] :
                         cha_ccr_q[hpm_pkg::BIT_MASTER])))) begin
                        st_q <= ST_SYNC;
                        cnt_q <= 2'h1;
                        acc_we_q <= wr_fall;
                        acc_b_q <= addr_q[7];
                        acc_mem_q <= sel_data;
                        acc_off_q <= off[5:0];
                        if (wr_fall) begin
                            bdl_q <= wdata;
                        end
                    end
                end
                ST_SYNC: begin
                    // access starts the third clock after the strobe
                    if (cnt_q == 2'(hpm_pkg::SYNC_CLKS - 1)) begin
                        st_q <= acc_mem_q ? ST_MEM : ST_CHAN;
                    end else begin
                        cnt_q <= cnt_q + 2'h1;
                    end
                end
                ST_MEM: begin
                    // single cycle, host always granted when memory live
                    if (mem_on_q) begin
                        if (!acc_we_q) begin
                            bdl_q <= i_mem_rdata;
                        end
                        st_q <= ST_IDLE;
                    end
                end
                ST_CHAN: begin
                    if (i_chan_done) begin
                        if (!acc_we_q) begin
                            bdl_q <= i_chan_rdata;
                        end
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // pointer: host loaded, optional increment after each buffer access
    always_ff @(posedge i_clock) begin
        if (rst) begin
            ptr_q <= 20'h00000;
        end else if (reg_wr && off == hpm_pkg::OFF_PTR_LO) begin
            ptr_q[7:0] <= wdata;
        end else if (reg_wr && off == hpm_pkg::OFF_PTR_MID) begin
            ptr_q[15:8] <= wdata;
        end else if (reg_wr && off == hpm_pkg::OFF_PTR_HI) begin
            ptr_q[19:16] <= wdata[3:0];
        end else if (st_q == ST_MEM && mem_on_q && opt2_q[hpm_pkg::BIT_AUTOINC]) begin
            ptr_q <= ptr_q + 20'h00001;
        end
    end

    // memory interface outputs; host over channels
    always_ff @(posedge i_clock) begin
        if (rst) begin
            o_mem_gnt <= hpm_pkg::GNT_NONE;
            o_mem_addr <= 20'h00000;
            o_mem_we <= 1'b0;
            o_mem_wdata <= 8'h00;
            o_refresh_force <= 1'b0;
        end else begin
            o_refresh_force <= ref_force;
            o_mem_addr <= ptr_q;
            o_mem_wdata <= bdl_q;
            o_mem_we <= mem_req_host && mem_on_q && acc_we_q;
            if (!mem_on_q) begin
                o_mem_gnt <= hpm_pkg::GNT_NONE;
            end else if (mem_req_host) begin
                o_mem_gnt <= hpm_pkg::GNT_HOST;
            end else if (i_cha_mem_req && !ref_force) begin
                o_mem_gnt <= hpm_pkg::GNT_CHA;
            end else if (i_chb_mem_req && !ref_force) begin
                o_mem_gnt <= hpm_pkg::GNT_CHB;
            end else begin
                o_mem_gnt <= hpm_pkg::GNT_NONE;
            end
        end
    end

    // channel cycle outputs and control-line enables
    always_ff @(posedge i_clock) begin
        if (rst) begin
            o_cha_cyc <= 1'b0;
            o_chb_cyc <= 1'b0;
            o_chan_addr <= 6'h00;
            o_chan_we <= 1'b0;
            o_chan_wdata <= 8'h00;
            o_cha_ctl_oe <= 1'b0;
            o_chb_ctl_oe <= 1'b0;
            o_mem_active <= 1'b0;
            o_sram_mode <= 1'b1;
        end else begin
            o_cha_cyc <= st_q == ST_CHAN && !acc_b_q;
            o_chb_cyc <= st_q == ST_CHAN && acc_b_q;
            o_chan_addr <= acc_off_q;
            o_chan_we <= acc_we_q;
            o_chan_wdata <= bdl_q;
            o_cha_ctl_oe <= cha_on_q;
            o_chb_ctl_oe <= chb_on_q;
            o_mem_active <= mem_on_q;
            o_sram_mode <= opt_q[hpm_pkg::BIT_SRAM];
        end
    end

    // read mux; registers and data latch answer at once
    logic [7:0] mstat, rdata;
    assign mstat = {3'h0, !mem_on_q, busy, 1'b0, birq_q, airq_q};
    always_comb begin
        rdata = 8'h00;
        if (sel_zero) begin
            rdata = 8'h00;
        end else if (sel_data || sel_chan) begin
            rdata = bdl_q;
        end else begin
            unique case (off)
                hpm_pkg::OFF_OPT: rdata = opt_q;
                hpm_pkg::OFF_OPT2: rdata = opt2_q;
                hpm_pkg::OFF_MSTAT: rdata = mstat;
                hpm_pkg::OFF_BDL: rdata = bdl_q;
                hpm_pkg::OFF_PTR_LO: rdata = ptr_q[7:0];
                hpm_pkg::OFF_PTR_MID: rdata = ptr_q[15:8];
                hpm_pkg::OFF_PTR_HI: rdata = {4'h0, ptr_q[19:16]};
                hpm_pkg::OFF_TSEL: rdata = tsel_q;
                hpm_pkg::OFF_AAUX: rdata = aaux_q;
                hpm_pkg::OFF_CCR: rdata = addr_q[7] ? chb_ccr_q : cha_ccr_q;
                default: rdata = 8'h00;
            endcase
        end
    end

    // host data drive during a qualified read
    always_ff @(posedge i_clock) begin
        if (rst) begin
            o_ad <= 8'h00;
            o_ad_oe <= 1'b0;
        end else begin
            o_ad <= rdata;
            o_ad_oe <= !s2_q.cs_n && !s2_q.rd_n;
        end
    end

    // ready: waitable drops on decode, non-waitable after strobe end
    logic pend_q;
    always_ff @(posedge i_clock) begin
        if (rst) begin
            o_rdy_n <= 1'b1;
            pend_q <= 1'b0;
        end else if (opt2_q[hpm_pkg::BIT_NON_WAITABLE_MODE]) begin
            if (strobe_on && (sel_data || sel_chan)) begin
                pend_q <= 1'b1;
            end else if (!busy) begin
                pend_q <= 1'b0;
            end
            o_rdy_n <= !((pend_q && strobe_end) || (busy && !o_rdy_n)
                || (pend_q && s2_q.rd_n && s2_q.wr_n && busy));
        end else begin
            pend_q <= 1'b0;
            // registers never hold the host
            o_rdy_n <= !(opt2_q[hpm_pkg::BIT_WAIT_LINE_ENABLE] && !s2_q.cs_n &&
                (sel_data || sel_chan) && (busy || strobe_on ||
                 s2_q.rd_n == s2_q.wr_n));
        end
    end

    AST_SOFT_RESET_CLEARS_IRQ: assert property (@(posedge i_clock)
        soft_reset_bit_q |=> !airq_q && !birq_q && !o_irq) else $error("soft reset kept irq");
    AST_SYNC_THREE: assert property (@(posedge i_clock) disable iff (rst)
        $rose(st_q == ST_SYNC) |-> ##1 (st_q == ST_SYNC) ##1 (st_q != ST_SYNC))
        else $error("sync not three clocks");
    AST_IRQ_HOLD: assert property (@(posedge i_clock) disable iff (rst)
        airq_q && !(clr_irq && wdata[hpm_pkg::BIT_AIRQ]) |=> airq_q)
        else $error("irq lost without clear");
    AST_HOST_FIRST: assert property (@(posedge i_clock) disable iff (rst)
        mem_req_host && mem_on_q |=> o_mem_gnt == hpm_pkg::GNT_HOST)
        else $error("host not first");
    AST_MEM_OFF: assert property (@(posedge i_clock) disable iff (rst)
        !mem_on_q |=> o_mem_gnt == hpm_pkg::GNT_NONE) else $error("memory live");
    AST_ZERO_READ: assert property (@(posedge i_clock) disable iff (rst)
        sel_zero |=> o_ad == 8'h00) else $error("zero slot not zero");
    AST_MASK: assert property (@(posedge i_clock) disable iff (rst)
        !opt2_q[hpm_pkg::BIT_GIE] |=> !o_irq) else $error("masked irq");
    AST_CHAN_OE: assert property (@(posedge i_clock) disable iff (rst)
        !cha_on_q |=> !o_cha_ctl_oe) else $error("channel driven early");
endmodule

// >>> hpm_pkg.sv
// package for the host port map, reset and ready block
package hpm_pkg;
    // register offsets within each half; bit 7 of the address picks the channel for the channel window and CCR, and is ignored otherwise
    localparam logic [6:0] OFF_OPT = 7'h60;
    localparam logic [6:0] OFF_OPT2 = 7'h62;
    localparam logic [6:0] OFF_MSTAT = 7'h64;
    localparam logic [6:0] OFF_UNUSED = 7'h66;
    localparam logic [6:0] OFF_BDL = 7'h68;
    localparam logic [6:0] OFF_PTR_LO = 7'h6A;
    localparam logic [6:0] OFF_PTR_MID = 7'h6C;
    localparam logic [6:0] OFF_PTR_HI = 7'h6E;
    localparam logic [6:0] OFF_ZERO_LO = 7'h70;
    localparam logic [6:0] OFF_ZERO_HI = 7'h76;
    localparam logic [6:0] OFF_TSEL = 7'h78;
    localparam logic [6:0] OFF_RTR = 7'h7A;
    localparam logic [6:0] OFF_DATA_PORT = 7'h7C;
    localparam logic [6:0] OFF_AAUX = 7'h7E;
    localparam logic [6:0] OFF_CHAN_REGS = 7'h40;
    localparam logic [6:0] OFF_CCR = 7'h42;
    // option register two fields
    localparam int BIT_AIE = 0;
    localparam int BIT_BIE = 1;
    localparam int BIT_GIE = 2;
    localparam int BIT_AUTOINC = 3;
    localparam int BIT_WAIT_LINE_ENABLE = 4;
    localparam int BIT_NON_WAITABLE_MODE = 5;
    // option register fields
    localparam int BIT_SRAM = 4;
    localparam logic [3:0] RRC_OFF = 4'h0;
    // master status fields
    localparam int BIT_AIRQ = 0;
    localparam int BIT_BIRQ = 1;
    localparam int BIT_BANR = 3;
    localparam int BIT_PRNR = 4;
    // reset/test fields
    localparam int BIT_SOFT_RESET_BIT = 7;
    // channel control: bus master bit
    localparam int BIT_MASTER = 7;
    // reset values
    localparam logic [7:0] RST_OPT = 8'h10;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // synchroniser length before a resource access starts
    localparam int SYNC_CLKS = 3;
    // clock and non-waitable ready delay
    localparam int CLK_NS = 100;
    localparam int NW_RDY_NS = 30;
    localparam int NW_RDY_CLKS = (NW_RDY_NS + CLK_NS - 1) / CLK_NS;
    // refresh queue depth and burst costs
    localparam logic [2:0] REF_QMAX = 3'h4;
    localparam int BYTE_CLKS = 2;
    localparam int RAS_CLKS = 4;
    localparam int FIFO_BYTES = 15;
    // host bus pin group, raw at the port, synchronised inside hpm_top
    typedef struct packed {
        logic ale;
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [7:0] ad;
    } hpm_host_t;
    // memory requesters
    typedef enum logic [1:0] {GNT_NONE, GNT_HOST, GNT_CHA, GNT_CHB} hpm_gnt_t;
endpackage

// >>> hpm_host_model.sv
// multiplexed-bus host model that drives the host port pins
`timescale 1ns/1ns
module hpm_host_model (
    input wire logic i_clock,
    input wire logic [7:0] i_ad,
    input wire logic i_rdy_n,
    output hpm_pkg::hpm_host_t o_host,
    output logic o_done,
    output logic [7:0] o_rdata
);
    // idle bus, nothing selected
    initial begin
        o_host = '{1'b0, 1'b1, 1'b1, 1'b1, 8'hA5};
        o_done = 1'b0;
        o_rdata = 8'h00;
    end
    // one cycle; strobe held until ready is back high, bounded
    task automatic cycle(input logic [7:0] a, input logic rd, input logic [7:0] wd);
        int n;
        n = 0;
        @(negedge i_clock);
        o_host.ad = a;
        o_host.ale = 1'b1;
        o_host.cs_n = 1'b0;
        repeat (2) @(negedge i_clock);
        o_host.ale = 1'b0;
        @(negedge i_clock);
        // released bus shows the inverse, never the old address
        o_host.ad = rd ? ~a : wd;
        o_host.rd_n = ~rd;
        o_host.wr_n = rd;
        repeat (6) @(posedge i_clock);
        while (i_rdy_n !== 1'b1 && n < 300) begin
            @(posedge i_clock);
            n++;
        end
        @(negedge i_clock);
        // read data taken off the edge, while the strobe still holds it
        o_rdata = i_ad;
        o_host.rd_n = 1'b1;
        o_host.wr_n = 1'b1;
        o_host.cs_n = 1'b1;
        o_host.ad = ~o_host.ad;
        o_done = rd;
        @(negedge i_clock);
        o_done = 1'b0;
    endtask
endmodule

// >>> hpm_top_bench.sv
// self-checking bench for the host port block
`timescale 1ns/1ns
module hpm_top_bench;
    logic i_clock, i_nrst, done, cha_req, chb_req, chan_done, ad_oe, rdy_n, irq, cha_cyc;
    logic chb_cyc, chan_we, cha_oe, chb_oe, mem_we, mem_active, sram_mode, ref_force;
    logic saw_wait, saw_a, saw_b, saw_host, saw_oe, saw_ref, tick;
    logic [8:0] gwr;
    logic [1:0] ev;
    logic [5:0] chan_addr;
    logic [7:0] ad, rdata, chan_wdata, mem_wdata, mem_rdata, chan_rdata, d;
    logic [19:0] mem_addr, gaddr, p;
    hpm_pkg::hpm_host_t host;
    hpm_pkg::hpm_gnt_t mem_gnt;
    logic [7:0] exp_q[$];
    int err_total, comparisons, cycles, clr_req, clr_seen;
    hpm_host_model host_m (.i_clock(i_clock), .i_ad(ad), .i_rdy_n(rdy_n), .o_host(host),
        .o_done(done), .o_rdata(rdata));
    hpm_top dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_host(host), .i_cha_mem_req(cha_req),
        .i_chb_mem_req(chb_req), .i_cha_irq_event(ev[0]), .i_chb_irq_event(ev[1]),
        .i_refresh_tick(tick), .i_mem_rdata(mem_rdata), .i_chan_done(chan_done),
        .i_chan_rdata(chan_rdata), .o_ad(ad), .o_ad_oe(ad_oe), .o_rdy_n(rdy_n), .o_irq(irq),
        .o_cha_cyc(cha_cyc), .o_chb_cyc(chb_cyc), .o_chan_addr(chan_addr), .o_chan_we(chan_we),
        .o_chan_wdata(chan_wdata), .o_cha_ctl_oe(cha_oe), .o_chb_ctl_oe(chb_oe),
        .o_mem_gnt(mem_gnt), .o_mem_addr(mem_addr), .o_mem_we(mem_we), .o_mem_wdata(mem_wdata),
        .o_mem_active(mem_active), .o_sram_mode(sram_mode), .o_refresh_force(ref_force));
    // 100 ns clock
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] wd);
        host_m.cycle(a, 1'b0, wd);
    endtask
    // read noted in the queue, compared by the watcher
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_m.cycle(a, 1'b1, 8'h00);
    endtask
    // flags are cleared by the sampling block at the next falling edge, their only writer
    task automatic clr();
        clr_req++;
        @(negedge i_clock);
    endtask
    task automatic pulse(input int ch);
        @(negedge i_clock);
        ev[ch] = 1'b1;
        @(negedge i_clock);
        ev = 2'h0;
        repeat (4) @(negedge i_clock);
    endtask
    // watcher: oldest note against each finished read; untracked reads skipped
    always @(posedge done) if (exp_q.size() != 0) chk(rdata, exp_q.pop_front());
    // samples outputs and answers channel cycles after one clock
    always @(negedge i_clock) begin
        if (clr_req != clr_seen) begin
            {saw_wait, saw_a, saw_b, saw_host, saw_oe, saw_ref} = 6'h00;
            clr_seen = clr_req;
        end
        if (rdy_n === 1'b0) saw_wait = 1'b1;
        if (ad_oe === 1'b1) saw_oe = 1'b1;
        if (ref_force === 1'b1) saw_ref = 1'b1;
        if (cha_cyc === 1'b1) saw_a = 1'b1;
        if (chb_cyc === 1'b1) saw_b = 1'b1;
        if (mem_gnt === hpm_pkg::GNT_HOST) begin
            saw_host = 1'b1;
            gaddr = mem_addr;
            gwr = {mem_we, mem_wdata};
        end
        chan_done <= (cha_cyc | chb_cyc) & ~chan_done;
    end
    // hang guard
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        {i_nrst, cha_req, chb_req, tick, ev} = '0;
        {mem_rdata, chan_rdata} = '0;
        void'($urandom(18416));
        repeat (5) @(negedge i_clock);
        i_nrst = 1'b1;
        chk(sram_mode, 1'b1);
        chk({mem_active, cha_oe, chb_oe, irq}, 4'h0);
        clr();
        rd(8'h60, 8'h10);
        d = 8'h10 | (8'($urandom) & 8'h07);
        wr(8'h63, d);
        rd(8'hE2, d);
        rd(8'hF6, 8'h00);
        chk({saw_oe, saw_wait}, 2'h2);
        $display("test registers done");
        for (int ch = 0; ch < 2; ch++) begin
            wr(8'h62, 8'h04 | (8'h01 << ch));
            pulse(ch);
            chk(irq, 1'b1);
            wr(8'h64, 8'h00);
            chk(irq, 1'b1);
            wr(8'hE4, 8'h01 << ch);
            chk(irq, 1'b0);
            wr(8'h62, 8'h04);
            pulse(ch);
            chk(irq, 1'b0);
            wr(8'h64, 8'h03);
        end
        $display("test interrupts done");
        wr(8'h62, 8'h10);
        wr(8'h42, 8'h80);
        chk({cha_oe, chb_oe}, 2'h2);
        clr();
        d = 8'($urandom);
        wr(8'h25, d);
        chk({saw_a, saw_wait, chan_we, chan_addr, chan_wdata}, {3'h7, 6'h24, d});
        clr();
        // refused access: the data latch keeps the last written byte
        rd(8'h90, d);
        chk(saw_b, 1'b0);
        wr(8'hC2, 8'h80);
        chan_rdata = 8'($urandom);
        rd(8'h91, chan_rdata);
        chk({saw_b, chan_we, chan_addr}, {2'h2, 6'h10});
        $display("test channels done");
        wr(8'h60, 8'h11); // option written only after the idle time
        chk(mem_active, 1'b1);
        clr();
        for (int k = 0; k < 4; k++) begin
            chk(saw_ref, 1'b0);
            @(negedge i_clock) tick = 1'b1;
            @(negedge i_clock) tick = 1'b0;
        end
        repeat (2) @(negedge i_clock);
        chk(saw_ref, 1'b1);
        wr(8'h62, 8'h08);
        p = 20'($urandom);
        wr(8'h6A, p[7:0]);
        wr(8'hEC, p[15:8]);
        wr(8'h6E, {4'h0, p[19:16]});
        mem_rdata = 8'($urandom);
        clr();
        {cha_req, chb_req} = 2'h3;
        host_m.cycle(8'h7C, 1'b1, 8'h00);
        {cha_req, chb_req} = 2'h0;
        chk({saw_host, gaddr}, {1'b1, p});
        rd(8'h68, mem_rdata);
        clr();
        host_m.cycle(8'hFD, 1'b1, 8'h00);
        chk({saw_host, gaddr}, {1'b1, p + 20'h1});
        clr();
        d = 8'($urandom);
        wr(8'h7D, d);
        chk({saw_host, gwr}, {2'h3, d});
        chk(gaddr, p + 20'h2);
        $display("test buffer done");
        wr(8'h7A, 8'h80);
        chk({cha_oe, chb_oe, mem_active}, 3'h0);
        rd(8'h62, 8'h00);
        rd(8'hE0, 8'h10);
        $display("test soft reset done");
        close_out();
    end
endmodule
